// >>> avss_cmd.v
// Task-file command engine for verify, recalibrate, sense and seek
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ns
`include "avss_defines.vh"
// What this block does
// - Codes 40h/41h verify sectors like a read, never DRQ, no data moved.
// - BSY rises on accepting verify and stays while verifying.
// - After last sector verified, BSY drops, then interrupt rises.
// - Clean verify leaves address registers at last sector verified.
// - Failing verify stops there, address registers hold failing sector.
// - On verify error, sector count holds sectors not yet verified.
// - LBA bits 27-24 head, 23-16 cyl high, 15-8 cyl low, 7-0 sector.
// - Upper nibble 1 is recalibrate: no media work, normal end.
// - Recalibrate zeroes cylinders and head; sector 1 in CHS, 0 in LBA.
// - Code 03h puts prior command's extended error code in error register.
// - Extended codes 00h none, 01h self test ok, 09h misc.
// - Extended codes 20h bad command, 21h bad head/sector, 2Fh overflow.
// - Extended codes 11h uncorrectable, 18h corrected, 1Fh aborted.
// - Voltage out of tolerance reported as 35h or 36h.
// - Media codes: self test, ID not found, spares, format, write fail.
// - Upper nibble 7 is seek: range check only, error when out of range.
// - Sector count 1..256, zero meaning 256.
module avss_cmd #(
  parameter NUM_CYLS = 16'd1024,
  parameter NUM_HEADS = 4'd8,
  parameter NUM_SECS = 8'd32,
  parameter LBA_CAP = 28'd262144
) (
  input wire sys_clk_in,
  input wire rst_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  output reg intrq_out,
  output reg media_req_out,
  output reg [27:0] media_addr_out,
  output reg media_lba_out,
  input wire media_ack_in,
  input wire media_err_in,
  input wire [7:0] media_code_in
);

  localparam ST_IDLE = 2'd0;
  localparam ST_REQ = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_DONE = 2'd3;

  reg [1:0] state_q;
  reg [7:0] feature_q;
  reg [7:0] seccnt_q;
  reg [7:0] secnum_q;
  reg [7:0] cyllo_q;
  reg [7:0] cylhi_q;
  reg [7:0] drvhd_q;
  reg [7:0] error_q;
  reg [7:0] sense_q;
  reg bsy_q;
  reg err_q;
  reg [8:0] remain_q;
  reg dp_wr_q;
  reg [2:0] dp_idx_q;

  wire lba_mode = drvhd_q[`AVSS_DH_LBA];
  wire [27:0] cur_lba = {drvhd_q[3:0], cylhi_q, cyllo_q, secnum_q};
  wire [15:0] cur_cyl = {cylhi_q, cyllo_q};
  // Status byte; DRQ stays low since no sector data ever moves
  reg [7:0] status;
  always @* begin
    status = 8'h00;
    status[`AVSS_ST_BSY] = bsy_q;
    status[`AVSS_ST_RDY] = ~bsy_q;
    status[`AVSS_ST_DSC] = ~bsy_q;
    status[`AVSS_ST_DRQ] = 1'b0;
    status[`AVSS_ST_ERR] = err_q;
  end

  // Range check: 0 = fine, otherwise the extended code to report
  function [7:0] range_code;
    input lba;
    input [27:0] a;
    input [15:0] cyl;
    input [3:0] hd;
    input [7:0] sn;
    begin
      range_code = `AVSS_EX_NONE;
      if (lba) begin
        if (a >= LBA_CAP)
          range_code = `AVSS_EX_OVFL;
      end else if (hd >= NUM_HEADS || sn == 8'h00 || sn > NUM_SECS) begin
        range_code = `AVSS_EX_BADADR;
      end else if (cyl >= NUM_CYLS) begin
        range_code = `AVSS_EX_OVFL;
      end
    end
  endfunction

  function [2:0] idx_of;
    input [31:0] a;
    begin
      idx_of = a[4:2];
    end
  endfunction

  wire [7:0] start_chk = range_code(lba_mode, cur_lba, cur_cyl, drvhd_q[3:0], secnum_q);
  wire ap_valid = hsel_in && hready_in && htrans_in[1];
  wire in_win = (haddr_in[31:`AVSS_ADDR_W] == 27'h0000000);
  wire [7:0] wbyte = hwdata_in[7:0];
  wire cmd_wr = dp_wr_q && (dp_idx_q == `AVSS_IDX_CMD) && !bsy_q;
  wire reg_wr = dp_wr_q && !bsy_q;
  wire is_fatal = media_err_in && (media_code_in != `AVSS_EX_CORR);

  // Next CHS/LBA address after the current sector
  reg [27:0] nxt_lba;
  reg [7:0] nxt_sn;
  reg [3:0] nxt_hd;
  reg [15:0] nxt_cyl;
  always @* begin
    nxt_lba = cur_lba + 28'd1;
    nxt_sn = secnum_q + 8'd1;
    nxt_hd = drvhd_q[3:0];
    nxt_cyl = cur_cyl;
    if (secnum_q >= NUM_SECS) begin
      nxt_sn = 8'h01;
      nxt_hd = drvhd_q[3:0] + 4'd1;
      if (drvhd_q[3:0] + 4'd1 >= NUM_HEADS) begin
        nxt_hd = 4'h0;
        nxt_cyl = cur_cyl + 16'd1;
      end
    end
  end

  // Bus slave: zero wait states, read data captured in the address phase
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      dp_wr_q <= 1'b0;
      dp_idx_q <= 3'h0;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      dp_wr_q <= ap_valid && hwrite_in && in_win;
      dp_idx_q <= idx_of(haddr_in);
      if (ap_valid && !hwrite_in) begin
        hrdata_out <= 32'h00000000;
        if (!in_win)
          hrdata_out <= 32'h00000000;
        else if (idx_of(haddr_in) == `AVSS_IDX_FEATURE)
          hrdata_out <= {24'h000000, error_q};
        else if (idx_of(haddr_in) == `AVSS_IDX_SECCNT)
          hrdata_out <= {24'h000000, seccnt_q};
        else if (idx_of(haddr_in) == `AVSS_IDX_SECNUM)
          hrdata_out <= {24'h000000, secnum_q};
        else if (idx_of(haddr_in) == `AVSS_IDX_CYLLO)
          hrdata_out <= {24'h000000, cyllo_q};
        else if (idx_of(haddr_in) == `AVSS_IDX_CYLHI)
          hrdata_out <= {24'h000000, cylhi_q};
        else if (idx_of(haddr_in) == `AVSS_IDX_DRVHD)
          hrdata_out <= {24'h000000, drvhd_q};
        else if (idx_of(haddr_in) == `AVSS_IDX_CMD)
          hrdata_out <= {24'h000000, status};
      end
    end
  end

  // Command engine and task file
  always @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      feature_q <= `AVSS_RST_BYTE;
      seccnt_q <= `AVSS_RST_SECNUM;
      secnum_q <= `AVSS_RST_SECNUM;
      cyllo_q <= `AVSS_RST_BYTE;
      cylhi_q <= `AVSS_RST_BYTE;
      drvhd_q <= `AVSS_RST_DRVHD;
      error_q <= `AVSS_EX_SELFOK;
      sense_q <= `AVSS_EX_NONE;
      bsy_q <= 1'b0;
      err_q <= 1'b0;
      remain_q <= 9'd0;
      intrq_out <= 1'b0;
      media_req_out <= 1'b0;
      media_addr_out <= 28'h0000000;
      media_lba_out <= 1'b0;
    end else begin
      // Reading status acknowledges the interrupt
      if (ap_valid && !hwrite_in && in_win && idx_of(haddr_in) == `AVSS_IDX_CMD)
        intrq_out <= 1'b0;
      // Task file writes are ignored while busy
      if (reg_wr) begin
        if (dp_idx_q == `AVSS_IDX_FEATURE)
          feature_q <= wbyte;
        else if (dp_idx_q == `AVSS_IDX_SECCNT)
          seccnt_q <= wbyte;
        else if (dp_idx_q == `AVSS_IDX_SECNUM)
          secnum_q <= wbyte;
        else if (dp_idx_q == `AVSS_IDX_CYLLO)
          cyllo_q <= wbyte;
        else if (dp_idx_q == `AVSS_IDX_CYLHI)
          cylhi_q <= wbyte;
        else if (dp_idx_q == `AVSS_IDX_DRVHD)
          drvhd_q <= wbyte;
      end
      case (state_q)
        ST_IDLE: begin
          if (cmd_wr) begin
            bsy_q <= 1'b1;
            err_q <= 1'b0;
            intrq_out <= 1'b0;
            error_q <= `AVSS_EX_NONE;
            state_q <= ST_DONE;
            if (wbyte == `AVSS_CMD_VFY0 || wbyte == `AVSS_CMD_VFY1) begin
              // Count of zero means 256 sectors
              remain_q <= (seccnt_q == 8'h00) ? 9'd256 : {1'b0, seccnt_q};
              sense_q <= `AVSS_EX_NONE;
              if (start_chk != `AVSS_EX_NONE) begin
                err_q <= 1'b1;
                error_q <= `AVSS_ER_IDNF;
                sense_q <= start_chk;
              end else begin
                state_q <= ST_REQ;
              end
            end else if (wbyte[7:4] == `AVSS_NIB_RECAL) begin
              // Low nibble and other fields are don't-care
              cylhi_q <= 8'h00;
              cyllo_q <= 8'h00;
              drvhd_q[3:0] <= 4'h0;
              secnum_q <= lba_mode ? 8'h00 : 8'h01;
              sense_q <= `AVSS_EX_NONE;
            end else if (wbyte == `AVSS_CMD_SENSE) begin
              // Code from the command just before this one
              error_q <= sense_q;
              sense_q <= `AVSS_EX_NONE;
            end else if (wbyte[7:4] == `AVSS_NIB_SEEK) begin
              sense_q <= start_chk;
              if (start_chk != `AVSS_EX_NONE) begin
                err_q <= 1'b1;
                error_q <= `AVSS_ER_IDNF;
              end
            end else begin
              err_q <= 1'b1;
              error_q <= `AVSS_ER_ABRT;
              sense_q <= `AVSS_EX_BADCMD;
            end
          end
        end
        ST_REQ: begin
          // Only a verify strobe goes out; no DRQ, no data path
          media_req_out <= 1'b1;
          media_addr_out <= lba_mode ? cur_lba
                                     : {drvhd_q[3:0], cylhi_q, cyllo_q, secnum_q};
          media_lba_out <= lba_mode;
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (media_ack_in) begin
            media_req_out <= 1'b0;
            if (is_fatal) begin
              // Stop at failing sector; address stays on it
              seccnt_q <= remain_q[7:0];
              err_q <= 1'b1;
              error_q <= `AVSS_ER_UNC;
              sense_q <= media_code_in;
              state_q <= ST_DONE;
            end else begin
              if (media_err_in)
                sense_q <= `AVSS_EX_CORR;
              if (remain_q == 9'd1) begin
                // Address left on last verified sector
                state_q <= ST_DONE;
              end else begin
                remain_q <= remain_q - 9'd1;
                if (lba_mode) begin
                  drvhd_q[3:0] <= nxt_lba[27:24];
                  cylhi_q <= nxt_lba[23:16];
                  cyllo_q <= nxt_lba[15:8];
                  secnum_q <= nxt_lba[7:0];
                end else begin
                  drvhd_q[3:0] <= nxt_hd;
                  cylhi_q <= nxt_cyl[15:8];
                  cyllo_q <= nxt_cyl[7:0];
                  secnum_q <= nxt_sn;
                end
                state_q <= ST_REQ;
              end
            end
          end
        end
        default: begin
          // BSY drops first; interrupt follows one cycle later
          if (bsy_q) begin
            bsy_q <= 1'b0;
          end else begin
            intrq_out <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// >>> avss_defines.vh
// Register indices, field positions, codes and reset values
`ifndef AVSS_DEFINES_VH
`define AVSS_DEFINES_VH
// Task-file register indices (byte address = 4 * index)
`define AVSS_IDX_FEATURE 3'h1
`define AVSS_IDX_SECCNT 3'h2
`define AVSS_IDX_SECNUM 3'h3
`define AVSS_IDX_CYLLO 3'h4
`define AVSS_IDX_CYLHI 3'h5
`define AVSS_IDX_DRVHD 3'h6
`define AVSS_IDX_CMD 3'h7
// Low address bits spanned by the task file window; bits above must be zero
`define AVSS_ADDR_W 5
// Status bit positions
`define AVSS_ST_BSY 7
`define AVSS_ST_RDY 6
`define AVSS_ST_DSC 4
`define AVSS_ST_DRQ 3
`define AVSS_ST_ERR 0
// Drive/head field positions
`define AVSS_DH_LBA 6
// Error register bits
`define AVSS_ER_UNC 8'h40
`define AVSS_ER_IDNF 8'h10
`define AVSS_ER_ABRT 8'h04
// Command codes
`define AVSS_CMD_VFY0 8'h40
`define AVSS_CMD_VFY1 8'h41
`define AVSS_CMD_SENSE 8'h03
`define AVSS_NIB_RECAL 4'h1
`define AVSS_NIB_SEEK 4'h7
// Extended error codes
`define AVSS_EX_NONE 8'h00
`define AVSS_EX_SELFOK 8'h01
`define AVSS_EX_MISC 8'h09
`define AVSS_EX_BADCMD 8'h20
`define AVSS_EX_BADADR 8'h21
`define AVSS_EX_OVFL 8'h2f
`define AVSS_EX_VOLT_A 8'h35
`define AVSS_EX_VOLT_B 8'h36
`define AVSS_EX_UNC 8'h11
`define AVSS_EX_CORR 8'h18
`define AVSS_EX_ABORT 8'h1f
`define AVSS_EX_IDNF 8'h10
`define AVSS_EX_SPARE 8'h3a
`define AVSS_EX_WRFAIL 8'h03
// Reset values
`define AVSS_RST_BYTE 8'h00
`define AVSS_RST_SECNUM 8'h01
`define AVSS_RST_DRVHD 8'ha0
`define AVSS_RST_STAT 8'h50
`endif

// >>> avss_media_model.sv
// Media model answering sector verify requests
`timescale 1ns/1ns
module avss_media_model (
  input wire clk_in,
  input wire rst_in,
  input wire req_in,
  input wire [3:0] dly_in,
  input wire [15:0] fail_at_in,
  input wire [7:0] code_in,
  output reg ack_out = 1'b0,
  output reg err_out = 1'b0,
  output reg [7:0] code_out = 8'h0,
  output reg [15:0] served_out = 16'h0
);
  reg [3:0] wait_q = 4'h0;
  // Err and code churn outside an answer so stale values never look valid
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    err_out <= ~err_out;
    code_out <= ~code_out;
    if (rst_in) begin
      wait_q <= 4'h0;
      served_out <= 16'h0;
    end else if (req_in && !ack_out) begin
      if (wait_q >= dly_in) begin
        ack_out <= 1'b1;
        err_out <= served_out == fail_at_in;
        code_out <= code_in;
        served_out <= served_out + 16'h1;
        wait_q <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule

// >>> avss_props.sv
// Port-level checker for the command engine
`timescale 1ns/1ns
module avss_props (
  input wire sys_clk_in,
  input wire rst_in,
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [31:0] hrdata_out,
  input wire hreadyout_out,
  input wire hresp_out,
  input wire intrq_out,
  input wire media_req_out,
  input wire [27:0] media_addr_out,
  input wire media_lba_out,
  input wire media_ack_in,
  input wire media_err_in
);
  reg st_q;
  // Marks the data phase of a status read
  always @(posedge sys_clk_in) begin
    st_q <= !rst_in && hsel_in && htrans_in[1] && !hwrite_in && haddr_in[4:2] == 3'h7;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  property p_okay; hreadyout_out && !hresp_out; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_rst; disable iff (1'b0) rst_in |=> !intrq_out && !media_req_out; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_req_hold; media_req_out && !media_ack_in |=> media_req_out; endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_req_drop; media_req_out && media_ack_in |=> !media_req_out; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held past answer");
  property p_addr_hold;
    media_req_out && !media_ack_in |=> $stable(media_addr_out) && $stable(media_lba_out);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("sector address moved");
  property p_quiet; media_req_out |-> !intrq_out; endproperty
  a_quiet: assert property (p_quiet) else $error("interrupt while verifying");
  property p_drq; st_q |-> !hrdata_out[3]; endproperty
  a_drq: assert property (p_drq) else $error("data request flag seen");
  property p_hi_bits; st_q |-> hrdata_out[31:8] == 24'h0; endproperty
  a_hi_bits: assert property (p_hi_bits) else $error("upper read lanes not zero");
  property p_busy; st_q && $past(media_req_out) |-> hrdata_out[7]; endproperty
  a_busy: assert property (p_busy) else $error("status not busy while verifying");
  property p_idle_irq; st_q && $past(intrq_out) |-> !hrdata_out[7]; endproperty
  a_idle_irq: assert property (p_idle_irq) else $error("busy still set with interrupt");
  c_fail: cover property (media_ack_in && media_err_in);
  c_irq: cover property ($rose(intrq_out));
  c_stat: cover property (st_q);
endmodule

// >>> avss_tb.sv
// Self-checking bench for the command engine
`timescale 1ns/1ns
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'b00;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg hsel = 1'b1;
  wire [31:0] hrdata;
  wire hready, hresp, intrq, mreq, mlba, mack, merr;
  wire [27:0] maddr;
  wire [7:0] mcode;
  wire [15:0] served;
  reg [3:0] dly = 4'h0;
  reg [15:0] fail_at = 16'hffff;
  reg [7:0] fcode = 8'h0;
  reg mon_on = 1'b0;
  reg [27:0] mon_addr = 28'h0;
  reg [31:0] r;
  reg [39:0] sk [0:5];
  integer error_cnt = 0;
  integer tests_run = 0;
  integer seed = 32'hb68b6b04;
  integer i;
  initial forever #20 clk = ~clk;
  avss_cmd #(.NUM_CYLS(16'd1024), .NUM_HEADS(4'd8), .NUM_SECS(8'd32), .LBA_CAP(28'd262144))
  dut (.sys_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .intrq_out(intrq),
    .media_req_out(mreq), .media_addr_out(maddr), .media_lba_out(mlba),
    .media_ack_in(mack), .media_err_in(merr), .media_code_in(mcode));
  avss_media_model u_media (.clk_in(clk), .rst_in(rst), .req_in(mreq), .dly_in(dly),
    .fail_at_in(fail_at), .code_in(fcode), .ack_out(mack), .err_out(merr),
    .code_out(mcode), .served_out(served));
  task check(input string what, input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task wait_hi(input integer lim, input sel);
    integer n;
    n = 0;
    while ((sel ? intrq : hready) !== 1'b1) begin
      @(posedge clk);
      n = n + 1;
      if (n > lim) begin
        error_cnt = error_cnt + 1;
        conclude;
      end
    end
  endtask
  task bus(input w, input [2:0] idx, input [7:0] d);
    haddr <= {27'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    wait_hi(100, 1'b0);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    @(posedge clk);
    wait_hi(100, 1'b0);
    r = hrdata;
  endtask
  task run(input [7:0] cmd, input [7:0] st);
    bus(1'b1, 3'h7, cmd);
    wait_hi(5000, 1'b1);
    bus(1'b0, 3'h7, 8'h0);
    check("status", r, {24'h0, st});
  endtask
  task load(input [7:0] c, sn, cl, ch, dh);
    bus(1'b1, 3'h2, c);
    bus(1'b1, 3'h3, sn);
    bus(1'b1, 3'h4, cl);
    bus(1'b1, 3'h5, ch);
    bus(1'b1, 3'h6, dh);
  endtask
  task regs(input [7:0] sn, cl, ch, dh);
    bus(1'b0, 3'h3, 8'h0);
    check("sector", r, {24'h0, sn});
    bus(1'b0, 3'h4, 8'h0);
    check("cyl_low", r, {24'h0, cl});
    bus(1'b0, 3'h5, 8'h0);
    check("cyl_high", r, {24'h0, ch});
    bus(1'b0, 3'h6, 8'h0);
    check("drv_head", r, {24'h0, dh});
  endtask
  task sense(input [7:0] e, c);
    bus(1'b0, 3'h1, 8'h0);
    check("error", r, {24'h0, e});
    run(8'h03, 8'h50);
    bus(1'b0, 3'h1, 8'h0);
    check("sense", r, {24'h0, c});
  endtask
  function [7:0] rest(input integer n, k);
    rest = n - k;
  endfunction
  task vfy(input [7:0] cnt, input integer k, input [7:0] c);
    integer n;
    reg [27:0] b, e;
    reg bad;
    n = (cnt == 8'h0) ? 256 : cnt;
    b = $random(seed) & 28'h1fff0;
    bad = c == 8'h11 && k < n;
    e = bad ? b + k : b + n - 1;
    dly <= $random(seed) & 4'h3;
    fail_at <= served + k;
    fcode <= c;
    mon_addr <= b;
    mon_on <= 1'b1;
    load(cnt, b[7:0], b[15:8], b[23:16], {4'he, b[27:24]});
    run({7'h20, b[4]}, bad ? 8'h51 : 8'h50);
    mon_on <= 1'b0;
    regs(e[7:0], e[15:8], e[23:16], {4'he, e[27:24]});
    if (bad) begin
      bus(1'b0, 3'h2, 8'h0);
      check("remaining", r, {24'h0, rest(n, k)});
    end
    sense(bad ? 8'h40 : 8'h00, k < n ? c : 8'h00);
  endtask
  always @(posedge clk) begin
    if (mack && mon_on) begin
      check("media_addr", {3'h0, mlba, maddr}, {4'h1, mon_addr});
      mon_addr <= mon_addr + 28'h1;
    end
  end
  initial begin
    sk[0] = 40'ha3_03_ff_20_00;
    sk[1] = 40'ha8_00_00_01_21;
    sk[2] = 40'ha0_04_00_01_2f;
    sk[3] = 40'ha0_00_00_21_21;
    sk[4] = 40'he0_03_ff_ff_00;
    sk[5] = 40'he0_04_00_00_2f;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, 3'h1, 8'h0);
    check("error_rst", r, 32'h01);
    regs(8'h01, 8'h00, 8'h00, 8'ha0);
    bus(1'b0, 3'h0, 8'h0);
    check("unmapped", r, 32'h0);
    // A transfer without select must leave the task file alone
    hsel <= 1'b0;
    bus(1'b1, 3'h3, 8'h5a);
    hsel <= 1'b1;
    bus(1'b0, 3'h3, 8'h0);
    check("unselected", r, 32'h01);
    for (i = 0; i < 2; i = i + 1) begin
      load($random(seed), $random(seed), $random(seed), $random(seed), i ? 8'he9 : 8'ha5);
      run({4'h1, 4'($random(seed))}, 8'h50);
      regs(i ? 8'h00 : 8'h01, 8'h00, 8'h00, i ? 8'he0 : 8'ha0);
    end
    for (i = 0; i < 6; i = i + 1) begin
      load($random(seed), sk[i][15:8], sk[i][23:16], sk[i][31:24], sk[i][39:32]);
      run({4'h7, 4'($random(seed))}, sk[i][7:0] != 8'h0 ? 8'h51 : 8'h50);
      sense(sk[i][7:0] != 8'h0 ? 8'h10 : 8'h00, sk[i][7:0]);
    end
    run(8'hee, 8'h51);
    sense(8'h04, 8'h20);
    vfy(8'h00, 300, 8'h00);
    vfy(8'h01, 0, 8'h11);
    vfy(8'h00, 255, 8'h11);
    vfy($random(seed) | 8'h4, 2, 8'h18);
    for (i = 0; i < 4; i = i + 1) vfy($random(seed), $random(seed) & 8'h7, 8'h11);
    // CHS verify wrapping sector and head into the next cylinder
    fail_at <= 16'hffff;
    load(8'h03, 8'h1f, 8'h05, 8'h00, 8'ha7);
    run(8'h40, 8'h50);
    regs(8'h01, 8'h06, 8'h00, 8'ha0);
    sense(8'h00, 8'h00);
    // Reset while a long verify is still busy
    load(8'h00, 8'h00, 8'h00, 8'h00, 8'he0);
    bus(1'b1, 3'h7, 8'h40);
    bus(1'b0, 3'h7, 8'h0);
    check("busy", r, 32'h80);
    bus(1'b0, 3'h7, 8'h0);
    check("busy_again", r, 32'h80);
    repeat (10) @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("intrq_rst", {31'h0, intrq}, 32'h0);
    bus(1'b0, 3'h7, 8'h0);
    check("status_rst", r, 32'h50);
    bus(1'b0, 3'h1, 8'h0);
    check("error_rst2", r, 32'h01);
    bus(1'b0, 3'h2, 8'h0);
    check("count_rst", r, 32'h01);
    regs(8'h01, 8'h00, 8'h00, 8'ha0);
    conclude;
  end
endmodule
bind avss_cmd avss_props u_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .intrq_out(intrq_out),
  .media_req_out(media_req_out), .media_addr_out(media_addr_out),
  .media_lba_out(media_lba_out), .media_ack_in(media_ack_in), .media_err_in(media_err_in));
